/* File: design/cmpd_pkg.sv */
// Package of constants, types and register map for the clock mode and power down block.
package cmpd_pkg;

    // System clock rate and the nominal internal RC rate.
    localparam int SYS_CLK_KHZ = 200000;
    localparam int SYS_CLK_PERIOD_NS = 5;
    localparam int RC_NOMINAL_KHZ = 4000;
    // System cycles per internal RC period, rounded down so the rate is never slow.
    localparam int RC_TICK_CYCLES = (SYS_CLK_KHZ / RC_NOMINAL_KHZ < 1) ? 1 : SYS_CLK_KHZ / RC_NOMINAL_KHZ;
    // Least time the core reset is held after a wakeup, rounded up to whole cycles.
    localparam int WAKE_HOLD_NS = 100;
    localparam int WAKE_HOLD_CYCLES = (WAKE_HOLD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [4:0] OFF_CONFIG = 5'h00;
    localparam logic [4:0] OFF_EXT_CONFIG = 5'h04;
    localparam logic [4:0] OFF_STATUS = 5'h08;
    localparam logic [4:0] OFF_WAKE_EDGE = 5'h0C;
    localparam logic [4:0] OFF_WAKE_ENABLE_N = 5'h10;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h14;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h18;

    // Oscillator modes held in the configuration word.
    typedef enum logic [3:0] {
        OSC_INT_RC = 4'h0,
        OSC_EXT_RC = 4'h1,
        OSC_LOW_POWER_XTAL_A = 4'h2,
        OSC_LOW_POWER_XTAL_B = 4'h3,
        OSC_NORMAL_XTAL_A = 4'h4,
        OSC_NORMAL_XTAL_B = 4'h5,
        OSC_HIGH_SPEED_XTAL_A = 4'h6,
        OSC_HIGH_SPEED_XTAL_B = 4'h7,
        OSC_HIGH_SPEED_XTAL_C = 4'h8
    } cmpd_osc_mode_e;

    // The 12-bit clock configuration word.
    typedef struct packed {
        logic [3:0] reserved;
        logic wdt_enable;
        logic turbo;
        logic [1:0] rc_divide_select;
        cmpd_osc_mode_e osc_mode;
    } cmpd_config_s;

    // Status register layout.
    typedef struct packed {
        logic sleeping;
        logic watchdog_timeout_flag;
        logic power_down_flag;
    } cmpd_status_s;

    // Power state, Gray coded along run, sleep, wake.
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_SLEEP = 2'b01,
        PWR_WAKE = 2'b11
    } cmpd_pwr_e;

    // Interrupt status bit positions.
    localparam int IRQ_WIDTH = 3;
    localparam int IRQ_SLEEP_BIT = 0;
    localparam int IRQ_WAKE_BIT = 1;
    localparam int IRQ_PIN_BIT = 2;

    // Reset values and reset vectors.
    localparam logic [11:0] CONFIG_RESET = 12'h000;
    localparam logic [7:0] WAKE_ENABLE_N_RESET = 8'hFF;
    localparam logic [7:0] WAKE_EDGE_RESET = 8'h00;
    localparam logic [11:0] RESET_VECTOR_SMALL = 12'h7FF;
    localparam logic [11:0] RESET_VECTOR_LARGE = 12'hFFF;

    // Internal RC division ratio per divide code; 128 gives 31.25 kHz from 4 MHz.
    function automatic logic [7:0] rc_divide_ratio(input logic [1:0] sel);
        unique case (sel)
            2'b00: rc_divide_ratio = 8'h01;
            2'b01: rc_divide_ratio = 8'h04;
            2'b10: rc_divide_ratio = 8'h10;
            2'b11: rc_divide_ratio = 8'h80;
        endcase
    endfunction

endpackage

/* File: design/cmpd_clock_power.sv */
// Clock source selection, instruction rate and power down control with an Avalon-MM register slave.
// What this block does
// - Compatible mode: one instruction per four clocks.
// - Turbo mode: one instruction per clock.
// - Clock mode from 12-bit word, programming only.
// - Internal RC source runs nominally at 4 MHz.
// - Two-bit field divides internal RC, down to 31.25kHz.
// - External RC mode clocks from primary pin.
// - Seven crystal modes: two low, two normal, three fast.
// - External clock drives primary pin in crystal modes.
// - Power down stops clocks; watchdog keeps own oscillator.
// - Leaving power down resets, fetch at top address.
// - Large variant only: extended bit keeps clock running in power down.
// - Sleep halts execution until a wakeup event.
// - Sleep with watchdog sets timeout, clears power-down.
// - Wake on watchdog, pin edge, clear, brown-out.
// - Any wakeup sets timeout and power-down flags.
// - Edge select one means falling, zero rising.
module cmpd_clock_power #(
    parameter bit LARGE_VARIANT = 1'b0, // Larger memory part with the sleep clock option.
    parameter int WAKE_PINS = 8 // Number of wake-capable port pins.
) (
    input wire logic sys_clk_i, // System clock, 200 MHz.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic [4:0] avs_address_i, // Avalon byte address.
    input wire logic avs_read_i, // Avalon read request.
    input wire logic avs_write_i, // Avalon write request.
    input wire logic [31:0] avs_writedata_i, // Avalon write data.
    input wire logic [3:0] avs_byteenable_i, // Avalon byte enables.
    output logic [31:0] avs_readdata_o, // Avalon read data.
    output logic avs_waitrequest_o, // Avalon wait request.
    input wire logic prog_mode_i, // Programming mode pin, high while programming.
    input wire logic primary_clock_pin_i, // Primary clock input pin.
    output logic secondary_clock_pin_o, // Secondary clock pin drive.
    output logic secondary_clock_pin_oe_n_o, // Secondary pin enable, low drives.
    input wire logic sleep_i, // Sleep instruction executed, one-cycle pulse.
    input wire logic wdt_overflow_i, // Watchdog overflow from its own oscillator.
    input wire logic [WAKE_PINS-1:0] port_wake_i, // Wake-capable port pins.
    input wire logic master_clear_n_i, // Master clear pin, active low.
    input wire logic brown_out_i, // Brown-out detector, active high.
    output logic core_clk_en_o, // One-cycle pulse per operating clock.
    output logic instr_en_o, // One-cycle pulse per instruction.
    output logic core_reset_o, // Core reset, active high.
    output logic [11:0] reset_vector_o, // Fetch address after reset.
    output logic watchdog_timeout_flag_o, // Watchdog timeout flag.
    output logic power_down_flag_o, // Power-down flag.
    output logic irq_o // Level interrupt.
);

    localparam int SYNC_W = WAKE_PINS + 5;
    localparam int RC_GAP = cmpd_pkg::RC_TICK_CYCLES;
    localparam int HOLD = cmpd_pkg::WAKE_HOLD_CYCLES;
    localparam logic [7:0] RC_CNT_LAST = 8'(cmpd_pkg::RC_TICK_CYCLES - 1);
    localparam logic [7:0] HOLD_LAST = 8'(cmpd_pkg::WAKE_HOLD_CYCLES - 1);

    cmpd_pkg::cmpd_config_s cfg_reg;
    logic [WAKE_PINS-1:0] wake_edge_select_reg, wake_enable_n_reg;
    logic [cmpd_pkg::IRQ_WIDTH-1:0] irq_status_reg, irq_mask_reg;
    cmpd_pkg::cmpd_pwr_e pwr_reg;
    logic [7:0] hold_cnt_reg, rc_cnt_reg, rc_div_cnt_reg;
    logic [1:0] phase_reg;
    logic [SYNC_W-1:0] sync1_reg, sync2_reg, sync3_reg;
    logic [31:0] rdata_reg;
    logic [11:0] reset_vector_reg;
    logic sleep_clock_disable_n_reg, to_reg, pd_reg, waitreq_reg, core_clk_en_reg;
    logic instr_en_reg, core_reset_reg, irq_reg, sec_pin_reg, sec_oe_n_reg;

    // Synchronised views of the asynchronous inputs, then the decoded control terms.
    logic prog_s, pclk_s, pclk_d, wdt_s, wdt_d, master_clear_n_n_s, bor_s;
    logic [WAKE_PINS-1:0] pin_s, pin_d, pin_hit;
    logic bus_req, bus_go, rc_tick, int_tick, src_tick;
    logic keep_clk, run_clock, is_xtal, wake_any, sleep_go;
    logic [cmpd_pkg::IRQ_WIDTH-1:0] irq_event;
    logic [31:0] wmask;

    assign {prog_s, pclk_s, wdt_s, master_clear_n_n_s, bor_s, pin_s} = sync2_reg;
    assign {pclk_d, wdt_d, pin_d} = {sync3_reg[SYNC_W-2], sync3_reg[SYNC_W-3], sync3_reg[WAKE_PINS-1:0]};

    // Two-flop synchronisers; a third stage only serves the edge detectors.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= {prog_mode_i, primary_clock_pin_i, wdt_overflow_i, master_clear_n_i, brown_out_i,
                          port_wake_i};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Per-pin wake detection against the selected edge.
    generate
        for (genvar i = 0; i < WAKE_PINS; i++) begin : g_pin
            assign pin_hit[i] = !wake_enable_n_reg[i] &&
                                (wake_edge_select_reg[i] ? (pin_d[i] && !pin_s[i]) : (!pin_d[i] && pin_s[i]));
        end
    endgenerate

    // Wake sources; a watchdog overflow counts only when the watchdog is enabled.
    assign wake_any = (cfg_reg.wdt_enable && wdt_s && !wdt_d) || (|pin_hit) || !master_clear_n_n_s || bor_s;
    assign sleep_go = (pwr_reg == cmpd_pkg::PWR_RUN) && sleep_i;

    // Internal RC period from the system clock, then the programmable divider.
    assign rc_tick = (rc_cnt_reg == RC_CNT_LAST);
    assign int_tick = rc_tick && (rc_div_cnt_reg == cmpd_pkg::rc_divide_ratio(cfg_reg.rc_divide_select) - 8'h01);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rc_cnt_reg <= '0;
            rc_div_cnt_reg <= '0;
        end else begin
            rc_cnt_reg <= rc_tick ? 8'h00 : rc_cnt_reg + 8'h01;
            if (int_tick) begin
                rc_div_cnt_reg <= '0;
            end else if (rc_tick) begin
                rc_div_cnt_reg <= rc_div_cnt_reg + 8'h01;
            end
        end
    end

    // Every mode other than internal RC takes its clock from the primary pin.
    // The pin is sampled, so it must stay well below half the system clock.
    assign is_xtal = (cfg_reg.osc_mode >= cmpd_pkg::OSC_LOW_POWER_XTAL_A) &&
                     (cfg_reg.osc_mode <= cmpd_pkg::OSC_HIGH_SPEED_XTAL_C);
    assign src_tick = (cfg_reg.osc_mode == cmpd_pkg::OSC_INT_RC) ? int_tick : (pclk_s && !pclk_d);

    // The sleep clock option exists only on the larger variant; its bit is active low.
    assign keep_clk = LARGE_VARIANT && sleep_clock_disable_n_reg;
    assign run_clock = (pwr_reg != cmpd_pkg::PWR_SLEEP) || keep_clk;

    // Operating clock and instruction enables; execution only advances while running.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            phase_reg <= '0;
            core_clk_en_reg <= 1'b0;
            instr_en_reg <= 1'b0;
        end else begin
            core_clk_en_reg <= src_tick && run_clock;
            if (pwr_reg != cmpd_pkg::PWR_RUN) begin
                phase_reg <= '0;
                instr_en_reg <= 1'b0;
            end else if (src_tick) begin
                phase_reg <= phase_reg + 2'b01;
                instr_en_reg <= cfg_reg.turbo || (phase_reg == 2'b11);
            end else begin
                instr_en_reg <= 1'b0;
            end
        end
    end

    // Crystal modes drive the inverted primary level on the secondary pin; other modes leave it open.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sec_pin_reg <= 1'b0;
            sec_oe_n_reg <= 1'b1;
        end else begin
            sec_pin_reg <= is_xtal && !pclk_s;
            sec_oe_n_reg <= !is_xtal;
        end
    end

    // Power state: sleep on the instruction, wake to a held core reset, then run.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pwr_reg <= cmpd_pkg::PWR_RUN;
            hold_cnt_reg <= '0;
            core_reset_reg <= 1'b1;
        end else begin
            unique case (pwr_reg)
                cmpd_pkg::PWR_RUN: begin
                    core_reset_reg <= 1'b0;
                    if (sleep_i) begin
                        pwr_reg <= cmpd_pkg::PWR_SLEEP;
                    end
                end
                cmpd_pkg::PWR_SLEEP: begin
                    hold_cnt_reg <= '0;
                    if (wake_any) begin
                        pwr_reg <= cmpd_pkg::PWR_WAKE;
                        core_reset_reg <= 1'b1;
                    end
                end
                cmpd_pkg::PWR_WAKE: begin
                    hold_cnt_reg <= hold_cnt_reg + 8'h01;
                    if (hold_cnt_reg == HOLD_LAST) begin
                        pwr_reg <= cmpd_pkg::PWR_RUN;
                        core_reset_reg <= 1'b0;
                    end
                end
                default: begin
                    pwr_reg <= cmpd_pkg::PWR_RUN;
                end
            endcase
        end
    end

    // Timeout and power-down flags; power-up reset sets both.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            to_reg <= 1'b1;
            pd_reg <= 1'b1;
        end else if (pwr_reg == cmpd_pkg::PWR_SLEEP && wake_any) begin
            to_reg <= 1'b1;
            pd_reg <= 1'b1;
        end else if (sleep_go && cfg_reg.wdt_enable) begin
            to_reg <= 1'b1;
            pd_reg <= 1'b0;
        end
    end

    // The reset vector depends only on the memory size of the variant.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reset_vector_reg <= LARGE_VARIANT ? cmpd_pkg::RESET_VECTOR_LARGE : cmpd_pkg::RESET_VECTOR_SMALL;
        end
    end

    // Bus handshake: one wait cycle, then the access completes while waitrequest is low.
    assign bus_req = avs_read_i || avs_write_i;
    assign bus_go = bus_req && !waitreq_reg;
    generate
        for (genvar b = 0; b < 4; b++) begin : g_be
            assign wmask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
        end
    endgenerate

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            waitreq_reg <= 1'b1;
            rdata_reg <= '0;
        end else begin
            waitreq_reg <= !(bus_req && waitreq_reg);
            if (avs_read_i && waitreq_reg) begin
                unique case (avs_address_i)
                    cmpd_pkg::OFF_CONFIG: rdata_reg <= 32'(cfg_reg);
                    cmpd_pkg::OFF_EXT_CONFIG: rdata_reg <= 32'(sleep_clock_disable_n_reg);
                    cmpd_pkg::OFF_STATUS: rdata_reg <= 32'(cmpd_pkg::cmpd_status_s'{pwr_reg != cmpd_pkg::PWR_RUN,
                                                                                    to_reg, pd_reg});
                    cmpd_pkg::OFF_WAKE_EDGE: rdata_reg <= 32'(wake_edge_select_reg);
                    cmpd_pkg::OFF_WAKE_ENABLE_N: rdata_reg <= 32'(wake_enable_n_reg);
                    cmpd_pkg::OFF_IRQ_STATUS: rdata_reg <= 32'(irq_status_reg);
                    cmpd_pkg::OFF_IRQ_MASK: rdata_reg <= 32'(irq_mask_reg);
                    default: rdata_reg <= '0;
                endcase
            end
        end
    end

    // Clock configuration is locked unless the programming pin is high.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cfg_reg <= cmpd_pkg::cmpd_config_s'(cmpd_pkg::CONFIG_RESET);
            sleep_clock_disable_n_reg <= 1'b1;
        end else if (bus_go && avs_write_i && prog_s) begin
            if (avs_address_i == cmpd_pkg::OFF_CONFIG) begin
                cfg_reg <= cmpd_pkg::cmpd_config_s'((avs_writedata_i[11:0] & wmask[11:0]) |
                                                   (12'(cfg_reg) & ~wmask[11:0]));
            end
            if (avs_address_i == cmpd_pkg::OFF_EXT_CONFIG && avs_byteenable_i[0]) begin
                sleep_clock_disable_n_reg <= avs_writedata_i[0];
            end
        end
    end

    // Run-time registers: wake pin setup and interrupt mask.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wake_edge_select_reg <= cmpd_pkg::WAKE_EDGE_RESET[WAKE_PINS-1:0];
            wake_enable_n_reg <= cmpd_pkg::WAKE_ENABLE_N_RESET[WAKE_PINS-1:0];
            irq_mask_reg <= '0;
        end else if (bus_go && avs_write_i) begin
            if (avs_address_i == cmpd_pkg::OFF_WAKE_EDGE && avs_byteenable_i[0]) begin
                wake_edge_select_reg <= avs_writedata_i[WAKE_PINS-1:0];
            end
            if (avs_address_i == cmpd_pkg::OFF_WAKE_ENABLE_N && avs_byteenable_i[0]) begin
                wake_enable_n_reg <= avs_writedata_i[WAKE_PINS-1:0];
            end
            if (avs_address_i == cmpd_pkg::OFF_IRQ_MASK && avs_byteenable_i[0]) begin
                irq_mask_reg <= avs_writedata_i[cmpd_pkg::IRQ_WIDTH-1:0];
            end
        end
    end

    // Sticky interrupt status, write one to clear; a new event beats a clear in the same cycle.
    assign irq_event[cmpd_pkg::IRQ_SLEEP_BIT] = sleep_go;
    assign irq_event[cmpd_pkg::IRQ_WAKE_BIT] = (pwr_reg == cmpd_pkg::PWR_SLEEP) && wake_any;
    assign irq_event[cmpd_pkg::IRQ_PIN_BIT] = |pin_hit;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_status_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            if (bus_go && avs_write_i && avs_address_i == cmpd_pkg::OFF_IRQ_STATUS && avs_byteenable_i[0]) begin
                irq_status_reg <= (irq_status_reg & ~avs_writedata_i[cmpd_pkg::IRQ_WIDTH-1:0]) | irq_event;
            end else begin
                irq_status_reg <= irq_status_reg | irq_event;
            end
            // Registered, so the interrupt follows the status by one cycle.
            irq_reg <= |(irq_status_reg & irq_mask_reg);
        end
    end

    assign avs_readdata_o = rdata_reg;
    assign avs_waitrequest_o = waitreq_reg;
    assign secondary_clock_pin_o = sec_pin_reg;
    assign secondary_clock_pin_oe_n_o = sec_oe_n_reg;
    assign core_clk_en_o = core_clk_en_reg;
    assign instr_en_o = instr_en_reg;
    assign core_reset_o = core_reset_reg;
    assign reset_vector_o = reset_vector_reg;
    assign watchdog_timeout_flag_o = to_reg;
    assign power_down_flag_o = pd_reg;
    assign irq_o = irq_reg;

    // Checks on the clocking and power sequence.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_sleep_entry;
        sleep_go && cfg_reg.wdt_enable;
    endsequence

    sequence s_wake_event;
        (pwr_reg == cmpd_pkg::PWR_SLEEP) && wake_any;
    endsequence

    AST_COMPAT_QUARTER: assert property (
        (instr_en_reg && !$past(cfg_reg.turbo)) |-> ($past(phase_reg) == 2'b11 && $past(src_tick)))
        else $error("compatible instruction not on phase wrap");
    AST_TURBO_EVERY: assert property (
        (pwr_reg == cmpd_pkg::PWR_RUN && cfg_reg.turbo && src_tick) |=> instr_en_reg)
        else $error("turbo instruction missed a clock");
    AST_CFG_LOCKED: assert property (
        !prog_s |=> $stable(cfg_reg) && $stable(sleep_clock_disable_n_reg))
        else $error("configuration changed outside programming");
    AST_RC_PERIOD: assert property (
        rc_tick |-> ##RC_GAP rc_tick)
        else $error("internal RC period wrong");
    AST_RC_DIVIDE: assert property (
        int_tick |-> rc_tick && rc_div_cnt_reg == cmpd_pkg::rc_divide_ratio(cfg_reg.rc_divide_select) - 8'h01)
        else $error("internal RC divide ratio wrong");
    AST_PIN_CLOCK: assert property (
        (cfg_reg.osc_mode != cmpd_pkg::OSC_INT_RC && pclk_s && !pclk_d && run_clock) |=> core_clk_en_reg)
        else $error("pin clock edge lost");
    AST_SLEEP_STOP: assert property (
        (pwr_reg == cmpd_pkg::PWR_SLEEP && !keep_clk) |=> !core_clk_en_reg && !instr_en_reg)
        else $error("clock ran in power down");
    AST_SLEEP_FLAGS: assert property (
        s_sleep_entry |=> to_reg && !pd_reg && pwr_reg == cmpd_pkg::PWR_SLEEP)
        else $error("sleep entry flags wrong");
    AST_WAKE_RESET: assert property (
        s_wake_event |=> (core_reset_reg && to_reg && pd_reg && pwr_reg == cmpd_pkg::PWR_WAKE) ##HOLD
                         (pwr_reg == cmpd_pkg::PWR_RUN && !core_reset_reg))
        else $error("wakeup reset sequence wrong");
    AST_EDGE_SELECT: assert property (
        (!wake_enable_n_reg[0] && wake_edge_select_reg[0] && !pin_d[0] && pin_s[0]) |-> !pin_hit[0])
        else $error("falling-edge pin woke on rise");

endmodule

/* File: test/cmpd_osc_model.sv */
// Behavioural external clock source that drives the primary clock pin.
module cmpd_osc_model #(
    parameter int HALF_NS = 50 // Half period of the source in ns.
) (
    input wire logic run_i, // Source powered and running.
    output logic pin_o // Primary clock pin drive.
);
    timeunit 1ns;
    timeprecision 1ps;
    // The pin sits low while unpowered; the secondary pin is left open, so it is not driven here.
    initial begin
        pin_o = 1'b0;
        forever begin
            #HALF_NS;
            pin_o = run_i ? ~pin_o : 1'b0;
        end
    end
endmodule

/* File: test/cmpd_clock_power_tb.sv */
// Self-checking bench for the clock mode and power down block.
module cmpd_clock_power_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, rd, wr, prog, slp, wdt, master_clear_n_n, bo, run, wt, sec, oe_n, cce, ien, crst, tof, pdf, irq, pin, t;
    logic [4:0] adr;
    logic [31:0] wd, rdat, q;
    logic [7:0] pw;
    logic [11:0] vec;
    int n_fail, samples_checked, c, k, g;
    cmpd_osc_model #(.HALF_NS(50)) i_osc (.run_i(run), .pin_o(pin));
    cmpd_clock_power i_dut (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .prog_mode_i(prog), .primary_clock_pin_i(pin), .secondary_clock_pin_o(sec),
        .secondary_clock_pin_oe_n_o(oe_n), .sleep_i(slp), .wdt_overflow_i(wdt), .port_wake_i(pw),
        .master_clear_n_i(master_clear_n_n), .brown_out_i(bo), .core_clk_en_o(cce), .instr_en_o(ien),
        .core_reset_o(crst), .reset_vector_o(vec), .watchdog_timeout_flag_o(tof), .power_down_flag_o(pdf),
        .irq_o(irq));
    // Free-running 200 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Prints the verdict and ends the run.
    task automatic finish_test;
        if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Compares a seen value with the expected one.
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", s, exp, seen);
        end
    endtask
    // Waits, bounded, until a flag is sampled high; returns the edges spent.
    task automatic wsig(ref logic s, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (s !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            n_fail++;
            finish_test();
        end
    endtask
    // One Avalon access; the request is held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 50);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
        if (n >= 50) begin
            n_fail++;
            finish_test();
        end
    endtask
    // Expected divide ratio per divide code.
    function automatic int ratio(input int s);
        return (s == 3) ? 128 : (1 << (2 * s));
    endfunction
    // Main sequence: reset, locks, clock rates, sleep and each wake source.
    initial begin
        {rst, rd, wr, adr, wd, prog, slp, wdt, bo, pw, run} = '0;
        rst = 1'b1;
        master_clear_n_n = 1'b1;
        n_fail = 0;
        samples_checked = 0;
        void'($urandom(32'h1d18d59c));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        chk("vector", 32'(vec), 32'h0000_07FF);
        bus(1'b0, cmpd_pkg::OFF_EXT_CONFIG, 32'h0);
        chk("ext config", q, 32'h0000_0001);
        bus(1'b0, 5'h1C, 32'h0);
        chk("unmapped", q, 32'h0000_0000);
        // Configuration is refused until programming mode is on.
        bus(1'b1, cmpd_pkg::OFF_CONFIG, 32'h0000_00C5);
        bus(1'b0, cmpd_pkg::OFF_CONFIG, 32'h0);
        chk("config locked", q, 32'h0000_0000);
        prog <= 1'b1;
        repeat (4) @(posedge clk);
        // Internal RC tick spacing for every divide code.
        for (k = 0; k < 4; k++) begin
            bus(1'b1, cmpd_pkg::OFF_CONFIG, 32'(k << 4));
            wsig(cce, c);
            wsig(cce, c);
            chk("rc gap", c, cmpd_pkg::RC_TICK_CYCLES * ratio(k));
        end
        // Pin-clocked modes with a random instruction rate each.
        run <= 1'b1;
        for (k = 1; k < 9; k++) begin
            t = 1'($urandom);
            bus(1'b1, cmpd_pkg::OFF_CONFIG, 32'(k) | (32'(t) << 6));
            repeat (2) @(posedge clk);
            chk("pin enable", 32'(oe_n), 32'(k < 2));
            c = 0;
            repeat (8) begin
                wsig(cce, g);
                if (ien === 1'b1) c++;
            end
            // Mid-way through the low half of the source clock, crystal modes drive the inverse.
            repeat (30) @(posedge clk);
            chk("secondary pin", 32'(sec), 32'(k >= 2));
            chk("instr count", c, t ? 8 : 2);
        end
        run <= 1'b0;
        bus(1'b1, cmpd_pkg::OFF_CONFIG, 32'h0000_0080);
        bus(1'b1, cmpd_pkg::OFF_WAKE_EDGE, 32'h0000_0001);
        bus(1'b1, cmpd_pkg::OFF_WAKE_ENABLE_N, 32'h0000_00FE);
        bus(1'b1, cmpd_pkg::OFF_IRQ_MASK, 32'h0000_0001);
        // Sleep, then wake by each source in turn; disabled pins toggle at random meanwhile.
        for (k = 0; k < 4; k++) begin
            bus(1'b1, cmpd_pkg::OFF_IRQ_STATUS, 32'h0000_0007);
            @(posedge clk);
            chk("irq cleared", 32'(irq), 32'h0);
            slp <= 1'b1;
            @(posedge clk);
            slp <= 1'b0;
            // The enables launched on the sleep edge itself still belong to run.
            @(posedge clk);
            c = 0;
            repeat (200) begin
                @(posedge clk);
                pw[7:1] <= 7'($urandom);
                if (cce === 1'b1 || ien === 1'b1) c++;
            end
            chk("clock in sleep", c, 0);
            chk("sleep flags", {tof, pdf}, 2'b10);
            bus(1'b0, cmpd_pkg::OFF_STATUS, 32'h0);
            chk("status", q, 32'h0000_0006);
            chk("irq raised", 32'(irq), 32'h1);
            case (k)
                0: wdt <= 1'b1;
                1: begin
                    pw[0] <= 1'b1;
                    repeat (20) @(posedge clk);
                    chk("rising edge ignored", 32'(crst), 32'h0);
                    pw[0] <= 1'b0;
                end
                2: master_clear_n_n <= 1'b0;
                default: bo <= 1'b1;
            endcase
            wsig(crst, c);
            chk("wake flags", {tof, pdf}, 2'b11);
            {wdt, bo} <= 2'b00;
            master_clear_n_n <= 1'b1;
            c = 0;
            do begin
                @(posedge clk);
                c++;
            end while (crst === 1'b1 && c < 100);
            chk("wake hold", c, cmpd_pkg::WAKE_HOLD_CYCLES);
            bus(1'b0, cmpd_pkg::OFF_IRQ_STATUS, 32'h0);
            chk("irq status", q & 32'h3, 32'h0000_0003);
        end
        finish_test();
    end
endmodule
